// ==== rtl/drive_status_word_encoder.sv ====
// Purpose: builds the status word of each axis once per control cycle
// Assumes: drive state machine and mode select live elsewhere
// Notes: object reads answer one cycle later; any write is refused
`timescale 1ns/1ps
`default_nettype none
module drive_status_word_encoder #(
  parameter int NAXES = status_word_pkg::NUM_AXES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic cycle_tick,
  input wire status_word_pkg::axis_in_s [NAXES-1:0] axis_in,
  input wire status_word_pkg::target_in_s [NAXES-1:0] target_in,
  input wire logic od_rd,
  input wire logic od_wr,
  input wire logic [15:0] od_index,
  output logic [15:0] od_rdata,
  output logic od_ack,
  output logic od_refused,
  output logic [NAXES-1:0][15:0] status_word,
  output logic [NAXES-1:0][31:0] target_pos
);
  import status_word_pkg::*;

  typedef struct packed {
    logic [NAXES-1:0][15:0] word;
    logic [15:0] rdata;
    logic ack;
    logic refused;
  } enc_state_s;

  enc_state_s state_reg;
  enc_state_s state_next;
  logic [NAXES-1:0] exceeded;
  logic [NAXES-1:0][15:0] word_new;

  genvar g;
  generate
    for (g = 0; g < NAXES; g++) begin : g_axis
      target_speed_check u_check (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .tin(target_in[g]),
        .target_pos(target_pos[g]),
        .exceeded(exceeded[g])
      );
    end
  endgenerate

  function automatic logic [7:0] low_code(input drive_state_e st);
    logic [7:0] c;
    c = LOW_NOT_READY;
    case (st)
      ST_NOT_READY: c = LOW_NOT_READY;
      ST_ON_DISABLED: c = LOW_ON_DISABLED;
      ST_READY: c = LOW_READY;
      ST_SWITCHED_ON: c = LOW_SWITCHED_ON;
      ST_OP_ENABLED: c = LOW_OP_ENABLED;
      ST_QUICK_STOP: c = LOW_QUICK_STOP;
      ST_FAULT_REACT: c = LOW_FAULT_REACT;
      ST_FAULT: c = LOW_FAULT;
      default: c = LOW_NOT_READY;
    endcase
    return c;
  endfunction

  // returns {bit13, bit12, bit10}
  function automatic logic [2:0] mode_bits(input axis_in_s a);
    logic reach;
    logic [2:0] m;
    // halt turns "reached" into "stopped" in the profile modes and in IP
    reach = a.halt ? a.axis_stopped : a.target_reached;
    m = 3'h0;
    case (a.mode)
      MODE_PP: m = {a.following_error, a.setpoint_busy,
        reach};
      MODE_IP: m = {1'b0, a.interp_enabled, reach};
      MODE_HM: begin
        if (a.homing_error) begin
          m = {1'b1, 1'b0, a.speed_zero};
        end else if (a.homing_attained) begin
          m = {1'b0, 1'b1, !a.homing_busy};
        end else begin
          m = {1'b0, 1'b0, !a.homing_busy};
        end
      end
      MODE_CSP: m = {a.following_error, a.target_accepted,
        a.target_reached};
      MODE_CSV: m = {1'b0, a.target_accepted, a.target_reached};
      MODE_CST: m = {1'b0, a.target_accepted, 1'b0};
      MODE_PV: m = {1'b0, a.speed_zero, reach};
      MODE_PT: m = {1'b0, 1'b0, reach};
      default: m = 3'h0;
    endcase
    return m;
  endfunction

  function automatic logic [15:0] compose(input axis_in_s a,
                                          input logic exc);
    logic [15:0] w;
    logic [2:0] m;
    logic pos_mode;
    w = {8'h00, low_code(a.state)};
    m = mode_bits(a);
    pos_mode = (a.mode == MODE_IP) || (a.mode == MODE_CSP);
    w[BIT_MAIN_POWER] = a.main_power;
    w[BIT_WARNING] = a.warning;
    w[BIT_ACTIVE_STOP] = a.active_mode_stop;
    w[BIT_REMOTE] = a.remote_busy;
    w[BIT_MODE_10] = m[0];
    w[BIT_INT_LIMIT] = a.sw_limit_hit | a.forward_overtravel_input
      | a.reverse_overtravel_input | (exc & pos_mode);
    w[BIT_MODE_12] = m[1];
    w[BIT_MODE_13] = m[2];
    w[BIT_TORQUE_LIM] = a.torque_limit_en;
    w[BIT_SAFETY] = a.safety_active;
    return w;
  endfunction

  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < NAXES; i++) begin
      word_new[i] = compose(axis_in[i], exceeded[i]);
    end
    if (cycle_tick) begin
      state_next.word = word_new;
    end
    state_next.ack = 1'b0;
    state_next.refused = 1'b0;
    if (od_rd || od_wr) begin
      state_next.rdata = 16'h0000;
      if (od_wr) begin
        state_next.refused = 1'b1;
      end else if (od_index == IDX_AXIS_A) begin
        state_next.rdata = state_reg.word[0];
        state_next.ack = 1'b1;
      end else if (od_index == IDX_AXIS_B && NAXES > 1) begin
        state_next.rdata = state_reg.word[NAXES-1];
        state_next.ack = 1'b1;
      end else begin
        state_next.refused = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign status_word = state_reg.word;
  assign od_rdata = state_reg.rdata;
  assign od_ack = state_reg.ack;
  assign od_refused = state_reg.refused;

  // checks on axis 0 cover the shared compose path
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence s_update;
    ce && cycle_tick;
  endsequence

  sequence s_hold;
    !ce || !cycle_tick;
  endsequence

  chk_reset_zero: assert property (
    $past(srst) |-> status_word[0] == STATUS_RESET)
    else $error("status word not zero after reset");

  chk_word_hold: assert property (
    s_hold |=> $stable(status_word))
    else $error("status word changed outside a control cycle");

  chk_write_refused: assert property (
    ce && od_wr |=> od_refused && !od_ack
      && ($stable(status_word[0]) || $past(cycle_tick)))
    else $error("write to status word was not refused");

  chk_read_word_a: assert property (
    ce && od_rd && !od_wr && od_index == IDX_AXIS_A
      |=> od_ack && od_rdata == $past(status_word[0]))
    else $error("read of axis a word wrong");

  chk_state_op_en: assert property (
    s_update ##0 axis_in[0].state == ST_OP_ENABLED
      |=> {status_word[0][6:5], status_word[0][3:0]} == 6'h17)
    else $error("operation enabled code wrong");

  chk_state_ready: assert property (
    s_update ##0 axis_in[0].state == ST_READY
      |=> {status_word[0][6:5], status_word[0][3:0]} == 6'h11)
    else $error("ready to switch on code wrong");

  chk_state_fault: assert property (
    s_update ##0 axis_in[0].state == ST_FAULT
      |=> status_word[0][3:0] == 4'h8 && !status_word[0][6])
    else $error("fault code wrong");

  chk_power_warn: assert property (
    s_update |=> status_word[0][BIT_MAIN_POWER] == $past(axis_in[0].main_power)
      && status_word[0][BIT_WARNING] == $past(axis_in[0].warning))
    else $error("power or warning bit wrong");

  chk_high_flags: assert property (
    s_update |=> status_word[0][BIT_ACTIVE_STOP]
      == $past(axis_in[0].active_mode_stop)
      && status_word[0][BIT_REMOTE] == $past(axis_in[0].remote_busy))
    else $error("active stop or remote bit wrong");

  chk_torque_safety: assert property (
    s_update |=> status_word[0][BIT_TORQUE_LIM]
      == $past(axis_in[0].torque_limit_en)
      && status_word[0][BIT_SAFETY] == $past(axis_in[0].safety_active))
    else $error("torque limit or safety bit wrong");

  chk_overtravel: assert property (
    s_update ##0 (axis_in[0].forward_overtravel_input
      || axis_in[0].reverse_overtravel_input)
      |=> status_word[0][BIT_INT_LIMIT])
    else $error("overtravel did not set internal limit");

  chk_pp_halt: assert property (
    s_update ##0 axis_in[0].mode == MODE_PP && axis_in[0].halt
      |=> status_word[0][BIT_MODE_10] == $past(axis_in[0].axis_stopped))
    else $error("halted bit 10 does not show stopped");

  chk_homing_done: assert property (
    s_update ##0 axis_in[0].mode == MODE_HM && !axis_in[0].homing_error
      && axis_in[0].homing_attained && !axis_in[0].homing_busy
      |=> {status_word[0][13:12], status_word[0][10]} == 3'b011)
    else $error("homing complete code wrong");

  chk_homing_error: assert property (
    s_update ##0 axis_in[0].mode == MODE_HM && axis_in[0].homing_error
      |=> status_word[0][13:12] == 2'b10
      && status_word[0][10] == $past(axis_in[0].speed_zero))
    else $error("homing error code wrong");

  chk_cst_zero: assert property (
    s_update ##0 axis_in[0].mode == MODE_CST
      |=> !status_word[0][BIT_MODE_10] && !status_word[0][BIT_MODE_13])
    else $error("cyclic torque bits 10 or 13 not zero");

  chk_pt_zero: assert property (
    s_update ##0 axis_in[0].mode == MODE_PT
      |=> status_word[0][13:12] == 2'b00)
    else $error("profile torque bits 12 or 13 not zero");

  chk_pv_speed: assert property (
    s_update ##0 axis_in[0].mode == MODE_PV
      |=> status_word[0][BIT_MODE_12] == $past(axis_in[0].speed_zero)
      && !status_word[0][BIT_MODE_13])
    else $error("profile velocity bits wrong");

  chk_target_discard: assert property (
    ce && exceeded[0] && $past(ce) && $changed(exceeded[0])
      |-> $stable(target_pos[0]))
    else $error("oversized target was taken");

  chk_cyc_accept: assert property (
    s_update ##0 axis_in[0].mode == MODE_CSP
      |=> status_word[0][BIT_MODE_12] == $past(axis_in[0].target_accepted)
      && status_word[0][BIT_MODE_13] == $past(axis_in[0].following_error))
    else $error("cyclic position bits 12 or 13 wrong");

  chk_state_disabled: assert property (
    s_update ##0 axis_in[0].state == ST_ON_DISABLED
      |=> {status_word[0][6:5], status_word[0][3:0]} == 6'h20)
    else $error("switch on disabled code wrong");

  chk_state_quick: assert property (
    s_update ##0 axis_in[0].state == ST_QUICK_STOP
      |=> {status_word[0][6:5], status_word[0][3:0]} == 6'h07)
    else $error("quick stop code wrong");

  chk_pp_bits: assert property (
    s_update ##0 axis_in[0].mode == MODE_PP && !axis_in[0].halt
      |=> status_word[0][BIT_MODE_10] == $past(axis_in[0].target_reached)
      && status_word[0][BIT_MODE_12] == $past(axis_in[0].setpoint_busy)
      && status_word[0][BIT_MODE_13] == $past(axis_in[0].following_error))
    else $error("profile position bits wrong");

  chk_ip_bits: assert property (
    s_update ##0 axis_in[0].mode == MODE_IP
      |=> status_word[0][BIT_MODE_12] == $past(axis_in[0].interp_enabled)
      && !status_word[0][BIT_MODE_13])
    else $error("interpolated bits 12 or 13 wrong");

  chk_homing_run: assert property (
    s_update ##0 axis_in[0].mode == MODE_HM && !axis_in[0].homing_error
      && !axis_in[0].homing_attained
      |=> status_word[0][13:12] == 2'b00
      && status_word[0][10] == !$past(axis_in[0].homing_busy))
    else $error("homing progress code wrong");

  chk_csv_bits: assert property (
    s_update ##0 axis_in[0].mode == MODE_CSV
      |=> !status_word[0][BIT_MODE_13]
      && status_word[0][BIT_MODE_12] == $past(axis_in[0].target_accepted))
    else $error("cyclic velocity bits wrong");

  chk_mode_other: assert property (
    s_update ##0 axis_in[0].mode == 8'h00
      |=> status_word[0][13:12] == 2'b00 && !status_word[0][BIT_MODE_10])
    else $error("unassigned mode bits not zero");

  chk_read_word_b: assert property (
    NAXES > 1 && ce && od_rd && !od_wr && od_index == IDX_AXIS_B
      |=> od_ack && od_rdata == $past(status_word[NAXES-1]))
    else $error("read of axis b word wrong");
endmodule // drive_status_word_encoder
`default_nettype wire

// ==== pkg/status_word_pkg.sv ====
// Purpose: constants and carriers for the per-axis drive status word
// Assumes: one control cycle per cycle_tick pulse, system clock 10 MHz
// Notes: the lower byte patterns exclude bits 4 and 7, which ride on top
package status_word_pkg;
  localparam int NUM_AXES = 2;
  localparam logic [15:0] IDX_AXIS_A = 16'h6041;
  localparam logic [15:0] IDX_AXIS_B = 16'h6841;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  localparam int BIT_MAIN_POWER = 4;
  localparam int BIT_WARNING = 7;
  localparam int BIT_ACTIVE_STOP = 8;
  localparam int BIT_REMOTE = 9;
  localparam int BIT_MODE_10 = 10;
  localparam int BIT_INT_LIMIT = 11;
  localparam int BIT_MODE_12 = 12;
  localparam int BIT_MODE_13 = 13;
  localparam int BIT_TORQUE_LIM = 14;
  localparam int BIT_SAFETY = 15;

  // low byte patterns, bits 4 and 7 left clear
  localparam logic [7:0] LOW_NOT_READY = 8'h00;
  localparam logic [7:0] LOW_ON_DISABLED = 8'h40;
  localparam logic [7:0] LOW_READY = 8'h21;
  localparam logic [7:0] LOW_SWITCHED_ON = 8'h23;
  localparam logic [7:0] LOW_OP_ENABLED = 8'h27;
  localparam logic [7:0] LOW_QUICK_STOP = 8'h07;
  localparam logic [7:0] LOW_FAULT_REACT = 8'h0f;
  localparam logic [7:0] LOW_FAULT = 8'h08;

  localparam logic [7:0] MODE_PP = 8'h01;
  localparam logic [7:0] MODE_PV = 8'h03;
  localparam logic [7:0] MODE_PT = 8'h04;
  localparam logic [7:0] MODE_HM = 8'h06;
  localparam logic [7:0] MODE_IP = 8'h07;
  localparam logic [7:0] MODE_CSP = 8'h08;
  localparam logic [7:0] MODE_CSV = 8'h09;
  localparam logic [7:0] MODE_CST = 8'h0a;

  localparam int SPEED_LIMIT_INC_PER_MS = 4194304;
  localparam int CTRL_CYCLE_US = 1000;
  localparam int US_PER_MS = 1000;

  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_ON_DISABLED = 8'h02,
    ST_READY = 8'h04,
    ST_SWITCHED_ON = 8'h08,
    ST_OP_ENABLED = 8'h10,
    ST_QUICK_STOP = 8'h20,
    ST_FAULT_REACT = 8'h40,
    ST_FAULT = 8'h80
  } drive_state_e;

  typedef struct packed {
    drive_state_e state;
    logic main_power;
    logic warning;
    logic active_mode_stop;
    logic remote_busy;
    logic sw_limit_hit;
    logic forward_overtravel_input;
    logic reverse_overtravel_input;
    logic torque_limit_en;
    logic safety_active;
    logic halt;
    logic [7:0] mode;
    logic target_reached;
    logic axis_stopped;
    logic setpoint_busy;
    logic following_error;
    logic homing_busy;
    logic homing_attained;
    logic homing_error;
    logic speed_zero;
    logic interp_enabled;
    logic target_accepted;
  } axis_in_s;

  typedef struct packed {
    logic valid;
    logic signed [31:0] target;
    logic signed [31:0] demand;
    logic [31:0] gear_num;
    logic [31:0] gear_den;
  } target_in_s;
endpackage

// ==== rtl/target_speed_check.sv ====
// Purpose: accept or discard a new target position by implied speed
// Assumes: one target offered per control cycle at most
// Notes: exceeded stays set until the next accepted target
`timescale 1ns/1ps
`default_nettype none
module target_speed_check #(
  parameter int LIMIT_INC_PER_MS = status_word_pkg::SPEED_LIMIT_INC_PER_MS,
  parameter int CYCLE_US = status_word_pkg::CTRL_CYCLE_US
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire status_word_pkg::target_in_s tin,
  output logic [31:0] target_pos,
  output logic exceeded
);
  import status_word_pkg::*;

  typedef struct packed {
    logic [31:0] pos;
    logic exceeded;
  } chk_state_s;

  chk_state_s state_reg;
  chk_state_s state_next;
  logic [32:0] step;
  logic [79:0] lhs;
  logic [79:0] rhs;

  always_comb begin
    state_next = state_reg;
    step = 33'(signed'({tin.target[31], tin.target})
      - signed'({tin.demand[31], tin.demand}));
    if (step[32]) begin
      step = 33'(~step + 33'h1);
    end
    // both sides scaled to increments per millisecond
    lhs = 80'(step) * 80'(tin.gear_num) * 80'(US_PER_MS);
    rhs = 80'(LIMIT_INC_PER_MS) * 80'(tin.gear_den) * 80'(CYCLE_US);
    if (tin.valid) begin
      if (lhs > rhs) begin
        state_next.exceeded = 1'b1;
      end else begin
        state_next.pos = tin.target;
        state_next.exceeded = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign target_pos = state_reg.pos;
  assign exceeded = state_reg.exceeded;
endmodule // target_speed_check
`default_nettype wire

// ==== tb/fieldbus_master_model.sv ====
// Purpose: master model that owns the halt request and the object port
// Assumes: one request in flight; answer seen just after the take edge
// Notes: the index is inverted when idle so a stale value cannot help
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model (
  input wire logic clk_sys,
  input wire logic [15:0] od_rdata,
  input wire logic od_ack,
  input wire logic od_refused,
  output logic od_rd,
  output logic od_wr,
  output logic [15:0] od_index,
  output logic halt
);
  initial begin
    od_rd = 1'b0;
    od_wr = 1'b0;
    od_index = 16'h0000;
    halt = 1'b0;
  end

  // halt is the control word bit 8 that qualifies the reached bit
  task automatic set_halt(input logic v);
    @(posedge clk_sys);
    halt <= v;
  endtask

  task automatic obj(input logic wr, input logic [15:0] idx,
      output logic [15:0] data, output logic ack, output logic refd);
    int n;
    @(posedge clk_sys);
    od_rd <= ~wr;
    od_wr <= wr;
    od_index <= idx;
    @(posedge clk_sys);
    od_rd <= 1'b0;
    od_wr <= 1'b0;
    od_index <= ~idx;
    n = 0;
    #1;
    while (!(od_ack || od_refused) && n < 4) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    data = od_rdata;
    ack = od_ack;
    refd = od_refused;
  endtask
endmodule // fieldbus_master_model
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the status word encoder
// Assumes: axis B stays simple; halt of axis A comes from the master model
// Notes: expectations are literal words, not taken from the design
`timescale 1ns/1ps
`default_nettype none
module tb;
  import status_word_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic cycle_tick = 1'b0;
  axis_in_s [1:0] ain = '0;
  axis_in_s [1:0] axis_w;
  target_in_s [1:0] tin = '0;
  logic od_rd, od_wr, halt_a, od_ack, od_refused, got_ack, got_ref;
  logic [15:0] od_index, od_rdata, rd_data;
  logic [1:0][15:0] status_word;
  logic [1:0][31:0] target_pos;
  int error_cnt = 0;
  int samples_checked = 0;
  drive_state_e st_tab [8] = '{ST_NOT_READY, ST_ON_DISABLED, ST_READY,
    ST_SWITCHED_ON, ST_OP_ENABLED, ST_QUICK_STOP, ST_FAULT_REACT, ST_FAULT};
  logic [7:0] low_tab [8] = '{8'h00, 8'h40, 8'h21, 8'h23, 8'h27, 8'h07,
    8'h0f, 8'h08};
  int flag_pos [7] = '{8, 9, 11, 11, 11, 14, 15};
  // mode, {halt,reach,stop,busy,ferr,hbusy,hdone,herr,zero,ipen,acc}, 13/12/10
  logic [21:0] mtab [17] = '{
    {MODE_PP, 11'h200, 3'h1}, {MODE_PP, 11'h600, 3'h0},
    {MODE_PP, 11'h500, 3'h1}, {MODE_PP, 11'h0c0, 3'h6},
    {MODE_IP, 11'h242, 3'h3}, {MODE_HM, 11'h020, 3'h0},
    {MODE_HM, 11'h000, 3'h1}, {MODE_HM, 11'h030, 3'h2},
    {MODE_HM, 11'h010, 3'h3}, {MODE_HM, 11'h038, 3'h4},
    {MODE_HM, 11'h00c, 3'h5}, {MODE_CSP, 11'h641, 3'h7},
    {MODE_CSV, 11'h241, 3'h3}, {MODE_CST, 11'h241, 3'h2},
    {MODE_PV, 11'h244, 3'h3}, {MODE_PT, 11'h2c7, 3'h1},
    {MODE_PT, 11'h600, 3'h0}};

  always #50 clk_sys = ~clk_sys;

  always_comb begin
    axis_w = ain;
    axis_w[0].halt = halt_a;
  end

  drive_status_word_encoder u_drive_status_word_encoder (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .cycle_tick(cycle_tick),
    .axis_in(axis_w), .target_in(tin), .od_rd(od_rd), .od_wr(od_wr),
    .od_index(od_index), .od_rdata(od_rdata), .od_ack(od_ack),
    .od_refused(od_refused), .status_word(status_word),
    .target_pos(target_pos));

  fieldbus_master_model u_fieldbus_master_model (
    .clk_sys(clk_sys), .od_rdata(od_rdata), .od_ack(od_ack),
    .od_refused(od_refused), .od_rd(od_rd), .od_wr(od_wr),
    .od_index(od_index), .halt(halt_a));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input axis_in_s a0, input axis_in_s a1);
    @(posedge clk_sys);
    ain <= {a1, a0};
    cycle_tick <= 1'b1;
    @(posedge clk_sys);
    cycle_tick <= 1'b0;
    #1;
  endtask

  task automatic offer(input int t, input int d, input int n, input int m);
    @(posedge clk_sys);
    tin[0] <= '{1'b1, t, d, n, m};
    @(posedge clk_sys);
    tin[0].valid <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic wr, input logic [15:0] idx);
    u_fieldbus_master_model.obj(wr, idx, rd_data, got_ack, got_ref);
    // a missing answer after the four-cycle wait in obj ends the run here with a verdict
    if (!(got_ack === 1'b1 || got_ref === 1'b1)) begin
      error_cnt++;
      $display("[FAIL] object answer expected 1 seen 0");
      give_verdict();
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end

  initial begin
    axis_in_s a;
    axis_in_s b;
    logic [7:0] m;
    logic [10:0] f;
    logic [2:0] e3;
    a = '0;
    b = '0;
    b.state = ST_NOT_READY;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk("reset words", 32'h0, status_word);
    rd(1'b0, IDX_AXIS_A);
    chk("reset read", 32'h20000, {got_ack, got_ref, rd_data});
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      a = '0;
      a.state = st_tab[i];
      a.main_power = i[0];
      a.warning = i[1];
      tick(a, b);
      chk("state code", {i[1], 2'b00, i[0], 4'h0} | low_tab[i],
        status_word[0]);
    end
    $display("test states done");
    for (int j = 0; j < 7; j++) begin
      a = '0;
      a.state = ST_NOT_READY;
      {a.safety_active, a.torque_limit_en, a.reverse_overtravel_input,
        a.forward_overtravel_input, a.sw_limit_hit, a.remote_busy,
        a.active_mode_stop} = 7'h01 << j;
      tick(a, b);
      chk("flag", 32'h1 << flag_pos[j], status_word[0]);
    end
    $display("test flags done");
    for (int i = 0; i < 17; i++) begin
      {m, f, e3} = mtab[i];
      a = '0;
      a.state = ST_NOT_READY;
      a.mode = m;
      {a.target_reached, a.axis_stopped, a.setpoint_busy, a.following_error,
        a.homing_busy, a.homing_attained, a.homing_error, a.speed_zero,
        a.interp_enabled, a.target_accepted} = f[9:0];
      u_fieldbus_master_model.set_halt(f[10]);
      tick(a, b);
      chk("mode", {e3[2:1], 1'b0, e3[0], 10'h000}, status_word[0]);
    end
    u_fieldbus_master_model.set_halt(1'b0);
    $display("test modes done");
    a = '0;
    a.state = ST_NOT_READY;
    a.mode = MODE_CSP;
    offer(100, 200, 1, 1);
    chk("target", 32'd100, target_pos[0]);
    offer(8388708, 100, 1, 2);
    chk("target", 32'd8388708, target_pos[0]);
    offer(2097153, 0, 2, 1);
    chk("target", 32'd8388708, target_pos[0]);
    chk("target b", 32'h0, target_pos[1]);
    a.mode = MODE_PV;
    tick(a, b);
    chk("overrun pv", 32'h0, status_word[0]);
    a.mode = MODE_CSP;
    tick(a, b);
    chk("overrun csp", 32'h0800, status_word[0]);
    offer(7, 0, 2, 1);
    tick(a, b);
    chk("overrun clear", 32'h0, status_word[0]);
    $display("test target done");
    a.state = ST_FAULT;
    a.warning = 1'b1;
    b.state = ST_OP_ENABLED;
    b.main_power = 1'b1;
    tick(a, b);
    chk("words", {16'h0037, 16'h0088}, status_word);
    rd(1'b0, IDX_AXIS_B);
    chk("read b", 32'h20037, {got_ack, got_ref, rd_data});
    rd(1'b0, IDX_AXIS_A);
    chk("read a", 32'h20088, {got_ack, got_ref, rd_data});
    rd(1'b1, IDX_AXIS_A);
    chk("write a", 32'h10000, {got_ack, got_ref, rd_data});
    rd(1'b0, 16'h6042);
    chk("unmapped", 32'h10000, {got_ack, got_ref, rd_data});
    chk("word kept", 32'h0088, status_word[0]);
    $display("test object port done");
    @(posedge clk_sys);
    ce <= 1'b0;
    tick(b, a);
    chk("ce hold", 32'h0088, status_word[0]);
    @(posedge clk_sys);
    ce <= 1'b1;
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk("second reset", 32'h0, status_word);
    $display("test hold and reset done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
